// *** lssc_top.sv ***
// Purpose: lane snapshot capture and single sample check, with their registers
// Assumes: lane data, error strobes and samples arrive on i_clk
// Notes: byte register port; reads answer one cycle after the request
`timescale 1ns/100ps
module lssc_top
#(
    parameter int unsigned LANE_W = lssc_pkg::LANE_W
)
(
    input wire logic i_clk,                         // link receive clock, 100 MHz
    input wire logic i_rst_n,                       // async reset, active low
    input wire lssc_pkg::lssc_reg_req_s i_reg,      // register request
    output logic [7:0] o_reg_rdata,                 // read data, registered
    input wire lssc_pkg::lssc_lane_s [7:0] i_lanes, // per-lane data and error
    input wire lssc_pkg::lssc_samples_t i_samples,  // received converter samples
    input wire logic i_samples_valid,               // samples present
    input wire logic [15:0] i_ref_sample,           // reference sample
    output logic [39:0] o_captured_lane_word,       // snapshot
    output logic o_sample_check_mismatch_flag       // check fail flag
);
    if (LANE_W != lssc_pkg::LANE_W)
        $error("lane width must match the 40-bit snapshot");

    logic [4:0] cap_ctrl_r;
    logic [7:0] chk_ctrl_r;
    logic [39:0] snap_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic chk_clear;
    logic cap_wr;
    logic sw_edge;
    logic err_hit;
    logic cap_fire;
    logic [2:0] lane_sel;
    logic trig_mode;
    logic [39:0] sel_data;
    logic sel_err;

    assign lane_sel = cap_ctrl_r[lssc_pkg::CAP_SEL_LSB +: lssc_pkg::CAP_SEL_W];
    assign trig_mode = cap_ctrl_r[lssc_pkg::CAP_MODE_BIT];
    // full 3-bit code indexes all eight lanes
    assign sel_data = i_lanes[lane_sel].data;
    assign sel_err = i_lanes[lane_sel].bit_err;

    assign cap_wr = i_reg.wr && (i_reg.addr == lssc_pkg::ADDR_CAP_CTRL);
    // edge is taken from the write itself, so no extra cycle of latency
    assign sw_edge = cap_wr && i_reg.wdata[lssc_pkg::CAP_TRIG_BIT]
        && !cap_ctrl_r[lssc_pkg::CAP_TRIG_BIT];
    assign err_hit = trig_mode && sel_err;
    assign cap_fire = trig_mode ? err_hit : sw_edge;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cap_ctrl_r <= lssc_pkg::CAP_CTRL_RST;
        else if (cap_wr)
            cap_ctrl_r <= i_reg.wdata[4:0];
    end

    // clear bit is stored as written; the write of a 1 or a rise of the enable bit clears the result
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            chk_ctrl_r <= lssc_pkg::CHK_CTRL_RST;
        else if (i_reg.wr && i_reg.addr == lssc_pkg::ADDR_CHK_CTRL)
            chk_ctrl_r <= i_reg.wdata;
    end

    assign chk_clear = i_reg.wr && (i_reg.addr == lssc_pkg::ADDR_CHK_CTRL)
        && i_reg.wdata[lssc_pkg::CHK_CLR_BIT];

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            snap_r <= lssc_pkg::CAP_DATA_RST;
        else if (cap_fire)
            snap_r <= sel_data;
    end

    always_comb
    begin
        rdata_nxt = 8'h00;
        case (i_reg.addr)
            lssc_pkg::ADDR_CAP_CTRL: rdata_nxt = {3'h0, cap_ctrl_r};
            lssc_pkg::ADDR_CAP_BYTE0: rdata_nxt = snap_r[7:0];
            lssc_pkg::ADDR_CAP_BYTE1: rdata_nxt = snap_r[15:8];
            lssc_pkg::ADDR_CAP_BYTE2: rdata_nxt = snap_r[23:16];
            lssc_pkg::ADDR_CAP_BYTE3: rdata_nxt = snap_r[31:24];
            lssc_pkg::ADDR_CAP_BYTE4: rdata_nxt = snap_r[39:32];
            lssc_pkg::ADDR_CHK_CTRL: rdata_nxt = chk_ctrl_r;
            lssc_pkg::ADDR_CHK_STAT: rdata_nxt = {7'h00, o_sample_check_mismatch_flag};
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rdata_r <= 8'h00;
        else if (i_reg.rd)
            rdata_r <= rdata_nxt;
    end

    assign o_reg_rdata = rdata_r;
    assign o_captured_lane_word = snap_r;

    lssc_sample_check u_check
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_enable(chk_ctrl_r[lssc_pkg::CHK_EN_BIT]),
        .i_clear(chk_clear),
        .i_sample_idx(chk_ctrl_r[lssc_pkg::CHK_IDX_LSB +: 4]),
        .i_conv_idx(chk_ctrl_r[lssc_pkg::CHK_CONV_LSB +: 2]),
        .i_samples(i_samples),
        .i_samples_valid(i_samples_valid),
        .i_ref_sample(i_ref_sample),
        .o_mismatch_flag(o_sample_check_mismatch_flag)
    );

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // the arm write itself must leave software mode stored for the fire to count
    sequence s_arm;
        cap_wr && !i_reg.wdata[lssc_pkg::CAP_TRIG_BIT] && !i_reg.wdata[lssc_pkg::CAP_MODE_BIT];
    endsequence

    sequence s_fire;
        cap_wr && i_reg.wdata[lssc_pkg::CAP_TRIG_BIT] && !i_reg.wdata[lssc_pkg::CAP_MODE_BIT];
    endsequence

    a_low_lanes: assert property (
        cap_fire && lane_sel < 3'h4 |=> snap_r == $past(i_lanes[lane_sel].data))
        else $error("low lane capture wrong");
    a_high_lanes: assert property (
        cap_fire && lane_sel >= 3'h4 |=> snap_r == $past(i_lanes[lane_sel].data))
        else $error("high lane capture wrong");
    a_sw_mode_only: assert property (
        !trig_mode && !cap_wr |=> $stable(snap_r))
        else $error("capture without software trigger");
    a_err_capture: assert property (
        trig_mode && i_lanes[lane_sel].bit_err |=> snap_r == $past(sel_data))
        else $error("error did not capture");
    a_rearm_capture: assert property (
        s_arm ##1 !cap_wr ##1 s_fire |=> snap_r == $past(sel_data))
        else $error("rearmed trigger did not capture");
    a_no_retrigger: assert property (
        cap_ctrl_r[lssc_pkg::CAP_TRIG_BIT] && !trig_mode |=> $stable(snap_r))
        else $error("capture without a rising trigger");
    a_byte_order: assert property (
        i_reg.rd && i_reg.addr == lssc_pkg::ADDR_CAP_BYTE4
        |=> o_reg_rdata == $past(snap_r[39:32]))
        else $error("snapshot byte order wrong");
    a_snap_hold: assert property (
        !cap_fire [*2] |=> $stable(snap_r))
        else $error("snapshot changed without capture");
endmodule

// *** lssc_pkg.sv ***
// Purpose: shared constants and carriers for lane snapshot and sample check
// Assumes: byte-wide register port, registers at their printed addresses
// Notes: lane and sample carriers are packed for simple port lists
package lssc_pkg;
    localparam int unsigned LANES = 8;
    localparam int unsigned LANE_W = 40;
    localparam int unsigned CONVS = 4;
    localparam int unsigned SAMPLES = 16;
    localparam int unsigned SAMPLE_W = 16;
    localparam int unsigned ADDR_W = 12;

    localparam logic [11:0] ADDR_CAP_CTRL = 12'h31e;
    localparam logic [11:0] ADDR_CAP_BYTE0 = 12'h31f;
    localparam logic [11:0] ADDR_CAP_BYTE1 = 12'h320;
    localparam logic [11:0] ADDR_CAP_BYTE2 = 12'h321;
    localparam logic [11:0] ADDR_CAP_BYTE3 = 12'h322;
    localparam logic [11:0] ADDR_CAP_BYTE4 = 12'h323;
    localparam logic [11:0] ADDR_CHK_CTRL = 12'h32c;
    localparam logic [11:0] ADDR_CHK_STAT = 12'h32f;

    // lane capture control fields
    localparam int unsigned CAP_TRIG_BIT = 0;
    localparam int unsigned CAP_MODE_BIT = 1;
    localparam int unsigned CAP_SEL_LSB = 2;
    localparam int unsigned CAP_SEL_W = 3;
    localparam logic [4:0] CAP_CTRL_RST = 5'h00;
    localparam logic [39:0] CAP_DATA_RST = 40'h00_0000_0000;

    // sample check control fields
    localparam int unsigned CHK_EN_BIT = 0;
    localparam int unsigned CHK_CLR_BIT = 1;
    localparam int unsigned CHK_CONV_LSB = 2;
    localparam int unsigned CHK_IDX_LSB = 4;
    localparam logic [7:0] CHK_CTRL_RST = 8'h00;

    typedef struct packed {
        logic [LANE_W-1:0] data;
        logic bit_err;
    } lssc_lane_s;

    typedef logic [CONVS-1:0][SAMPLES-1:0][SAMPLE_W-1:0] lssc_samples_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } lssc_reg_req_s;
endpackage

// *** lssc_sample_check.sv ***
// Purpose: compare one chosen converter sample with a reference sample
// Assumes: samples and valid are synchronous to i_clk
// Notes: mismatch flag is sticky; a new mismatch beats a clear
`timescale 1ns/100ps
module lssc_sample_check
(
    input wire logic i_clk,                    // link receive clock
    input wire logic i_rst_n,                  // async reset, active low
    input wire logic i_enable,                 // check running
    input wire logic i_clear,                  // one-cycle result clear
    input wire logic [3:0] i_sample_idx,       // sample within frame
    input wire logic [1:0] i_conv_idx,         // converter channel
    input wire lssc_pkg::lssc_samples_t i_samples, // received samples
    input wire logic i_samples_valid,          // samples present this cycle
    input wire logic [15:0] i_ref_sample,      // expected sample
    output logic o_mismatch_flag               // sticky fail flag
);
    logic en_r;
    logic flag_r;
    logic [15:0] picked;
    logic miss;
    logic restart;

    assign picked = i_samples[i_conv_idx][i_sample_idx];
    assign miss = i_enable && i_samples_valid && (picked != i_ref_sample);
    assign restart = i_enable && !en_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            en_r <= 1'b0;
        else
            en_r <= i_enable;
    end

    // set wins over clear so a mismatch in the clear cycle survives
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            flag_r <= 1'b0;
        else if (miss)
            flag_r <= 1'b1;
        else if (i_clear || restart)
            flag_r <= 1'b0;
    end

    assign o_mismatch_flag = flag_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_restart;
        !i_enable ##1 i_enable;
    endsequence

    a_mismatch_sets: assert property (
        i_enable && i_samples_valid && i_samples[i_conv_idx][i_sample_idx] != i_ref_sample
        |=> o_mismatch_flag)
        else $error("mismatch did not set flag");
    a_match_no_set: assert property (
        !o_mismatch_flag && !(i_enable && i_samples_valid
        && i_samples[i_conv_idx][i_sample_idx] != i_ref_sample) |=> !o_mismatch_flag)
        else $error("flag set without mismatch");
    a_disabled_hold: assert property (
        !i_enable && !i_clear |=> $stable(o_mismatch_flag))
        else $error("flag moved while disabled");
    a_clear_works: assert property (
        i_clear && !i_enable |=> !o_mismatch_flag)
        else $error("clear did not clear flag");
    a_flag_sticky: assert property (
        o_mismatch_flag && !i_clear && !restart |=> o_mismatch_flag)
        else $error("flag dropped on its own");
    a_restart_clears: assert property (
        s_restart ##0 !i_samples_valid |=> !o_mismatch_flag)
        else $error("restart did not clear flag");
    a_conv_pick: assert property (
        i_enable && i_samples_valid && i_conv_idx == 2'h3
        && i_samples[3][i_sample_idx] != i_ref_sample |=> o_mismatch_flag)
        else $error("converter select wrong");
endmodule

// *** lssc_link_model.sv ***
// Purpose: link transmitter stand-in driving lane words and converter samples
// Assumes: lane error levels are commanded by the bench
// Notes: lane words change every cycle so a stale snapshot shows
`timescale 1ns/100ps
module lssc_link_model
(
    input wire logic i_clk,                      // link clock
    input wire logic i_rst_n,                    // reset, active low
    input wire logic [31:0] i_seed,              // data scramble
    input wire logic [7:0] i_err,                // lanes to flag in error
    output lssc_pkg::lssc_lane_s [7:0] o_lanes,  // lane words
    output lssc_pkg::lssc_samples_t o_samples,   // converter samples
    output logic o_valid                         // samples present
);
    logic [31:0] cnt_r;
    always_ff @(posedge i_clk or negedge i_rst_n)
        if (!i_rst_n)
            cnt_r <= 32'h0;
        else
            cnt_r <= cnt_r + 32'h1;
    always_comb
    begin
        for (int k = 0; k < 8; k++)
        begin
            o_lanes[k].data = {8'(k), cnt_r ^ i_seed};
            o_lanes[k].bit_err = i_err[k];
        end
        // sample word encodes its own place, so a wrong pick mismatches
        for (int c = 0; c < 4; c++)
            for (int s = 0; s < 16; s++)
                o_samples[c][s] = {4'(c), 4'(s), 8'h5a};
    end
    // valid every other cycle: the check must wait for it
    assign o_valid = cnt_r[0];
endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for lane snapshot and sample check
// Assumes: reads answer one edge after the request
// Notes: read results are noted in a queue and checked by a monitor
`timescale 1ns/100ps
module tb_top;
    logic i_clk, i_rst_n, valid, flag, pend_r;
    lssc_pkg::lssc_reg_req_s req;
    lssc_pkg::lssc_lane_s [7:0] lanes;
    lssc_pkg::lssc_samples_t samples;
    logic [7:0] rdata, err;
    logic [15:0] ref_s;
    logic [39:0] cap, snap;
    logic [31:0] seed, rnd;
    logic [7:0] exp_q[$];
    int bad_count, total_checks;
    lssc_link_model link_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_seed(seed), .i_err(err),
        .o_lanes(lanes), .o_samples(samples), .o_valid(valid));
    lssc_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg(req), .o_reg_rdata(rdata),
        .i_lanes(lanes), .i_samples(samples), .i_samples_valid(valid), .i_ref_sample(ref_s),
        .o_captured_lane_word(cap), .o_sample_check_mismatch_flag(flag));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk_cap(input logic [39:0] e);
        total_checks++;
        if (cap !== e)
        begin
            bad_count++;
            $display("ERROR %0t snapshot %h expected %h", $time, cap, e);
        end
    endtask
    task automatic chk_flag(input logic e);
        total_checks++;
        if (flag !== e)
        begin
            bad_count++;
            $display("ERROR %0t flag %b expected %b", $time, flag, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        req <= {a, 2'b10, d};
        @(posedge i_clk);
        req <= {a, 2'b00, d};
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge i_clk);
        req <= {a, 2'b01, 8'h00};
        exp_q.push_back(e);
        @(posedge i_clk);
        req <= {a, 2'b00, 8'h00};
    endtask
    task automatic rd_word(input logic [39:0] w);
        for (int b = 0; b < 5; b++)
            rd(lssc_pkg::ADDR_CAP_BYTE0 + 12'(b), w[8*b +: 8]);
        chk_cap(w);
    endtask
    task automatic chk_rd(input logic [7:0] e);
        total_checks++;
        if (rdata !== e)
        begin
            bad_count++;
            $display("ERROR %0t read %h expected %h", $time, rdata, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        pend_r <= req.rd;
        if (pend_r)
            chk_rd(exp_q.pop_front());
    end
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial
    begin
        // about 840 cycles expected
        #200000;
        bad_count++;
        stop_test();
    end
    initial
    begin
        i_rst_n = 1'b0;
        req = '0;
        seed = 32'h0;
        // every lane in error: software mode must ignore it
        err = 8'hff;
        ref_s = 16'h0;
        rnd = 32'h84a980c3;
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int a = 12'h31e; a <= 12'h330; a++)
            if (a <= 12'h323 || a == 12'h32c || a == 12'h32f || a == 12'h330)
                rd(12'(a), 8'h00);
        $display("reset values done");
        for (int l = 0; l < 8; l++)
        begin
            rnd = xs(rnd);
            seed <= rnd;
            wr(lssc_pkg::ADDR_CAP_CTRL, {3'b000, 3'(l), 2'b00});
            wr(lssc_pkg::ADDR_CAP_CTRL, {3'b000, 3'(l), 2'b01});
            snap = lanes[l].data;
            // second set without clearing must not capture again
            wr(lssc_pkg::ADDR_CAP_CTRL, {3'b000, 3'(l), 2'b01});
            rd_word(snap);
            wr(lssc_pkg::ADDR_CAP_CTRL, {3'b111, 3'(l), 2'b00});
            rd(lssc_pkg::ADDR_CAP_CTRL, {3'b000, 3'(l), 2'b00});
        end
        $display("software capture done");
        err <= 8'h00;
        wr(lssc_pkg::ADDR_CAP_CTRL, 8'h16);
        wr(lssc_pkg::ADDR_CAP_CTRL, 8'h17);
        rd_word(snap);
        @(posedge i_clk);
        err <= 8'h08;
        @(posedge i_clk);
        err <= 8'h00;
        rd_word(snap);
        @(posedge i_clk);
        err <= 8'h20;
        @(posedge i_clk);
        err <= 8'h00;
        snap = lanes[5].data;
        wr(lssc_pkg::ADDR_CAP_BYTE0, 8'hff);
        rd_word(snap);
        wr(lssc_pkg::ADDR_CAP_CTRL, 8'h00);
        $display("error capture done");
        for (int c = 0; c < 4; c++)
            for (int s = 0; s < 16; s++)
            begin
                rnd = xs(rnd);
                wr(lssc_pkg::ADDR_CHK_CTRL, 8'h00);
                ref_s <= {4'(c), 4'(s), 8'h5a} ^ (rnd[0] ? {rnd[15:1], 1'b1} : 16'h0);
                wr(lssc_pkg::ADDR_CHK_CTRL, {4'(s), 2'(c), 2'b01});
                repeat (3) @(posedge i_clk);
                chk_flag(rnd[0]);
                rd(lssc_pkg::ADDR_CHK_STAT, {7'h00, rnd[0]});
            end
        // disable first: a last mismatch in the clear cycle would win
        wr(lssc_pkg::ADDR_CHK_CTRL, 8'h00);
        wr(lssc_pkg::ADDR_CHK_CTRL, 8'h02);
        ref_s <= 16'hffff;
        repeat (4) @(posedge i_clk);
        rd(lssc_pkg::ADDR_CHK_STAT, 8'h00);
        wr(lssc_pkg::ADDR_CHK_CTRL, 8'h01);
        repeat (3) @(posedge i_clk);
        ref_s <= 16'h005a;
        repeat (4) @(posedge i_clk);
        chk_flag(1'b1);
        rd(lssc_pkg::ADDR_CHK_STAT, 8'h01);
        wr(lssc_pkg::ADDR_CHK_CTRL, 8'h03);
        repeat (4) @(posedge i_clk);
        rd(lssc_pkg::ADDR_CHK_STAT, 8'h00);
        $display("sample check done");
        repeat (3) @(posedge i_clk);
        stop_test();
    end
endmodule
